// File: logic/rsc_reset_source_controller.v
// Function
// - Missing clock timeout resets when detector enabled
// - Bit 2 writes detector enable, reads flag
// - Reset pin untouched by internal sources except supply monitor
// - Bit 5 selects comparator; low output resets
// - Watchdog enabled, clock divided twelve, after reset
// - Watchdog timeout resets; bit 3 read-only flag
// - Flash write above limit causes reset
// - Code read or branch above limit resets
// - Security-blocked flash access causes reset
// - Flash write with monitor off resets
// - Bit 6 flags flash error, read-only
// - Bit 4 one forces reset; zero ignored
// - Bit 7 selects USB bus reset source
// - Bus-power detect matching polarity also resets
// - Bit 1 power-on flag; selects supply monitor
// - Bit 0 flags external pin reset
// - Read-modify-write sees enables, and flags only on bits 0, 3 and 6
// - Execution waits five microseconds after release
// - Non power-on resets clear power-on flag
`timescale 1ns/1ps
`include "rsc_map.vh"

module rsc_reset_source_controller #(
  parameter FLASH_64K = 1
) (
  input  wire        clk,
  input  wire        nrst,
  // Register bus
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_rd,
  input  wire        sfr_rmw,
  output reg  [7:0]  sfr_rdata,
  // Asynchronous reset requests
  input  wire        pin_rst_n,
  input  wire        mcd_oneshot_expired,
  input  wire        vdd_below_thresh,
  input  wire        cmp0_out,
  input  wire        usb_bus_reset,
  input  wire        vbus_level,
  // Same-domain requests and status
  input  wire        vdd_mon_enabled,
  input  wire        usb_enabled,
  input  wire        bus_power_polarity,
  input  wire        wdt_timeout,
  input  wire        program_store_write_enable,
  input  wire        xwr_valid,
  input  wire [15:0] xwr_addr,
  input  wire        code_space_read_valid,
  input  wire [15:0] code_space_read_addr,
  input  wire        fetch_valid,
  input  wire [15:0] fetch_addr,
  input  wire        flash_sec_block,
  input  wire        flash_wr_attempt,
  // Outputs
  output reg         sys_rst_n,
  output reg         rst_pin_out,
  output reg         rst_pin_oe,
  output reg         wdt_force_default,
  output reg         wdt_clk_en,
  output reg         mcd_enable,
  output reg         vdd_mon_select
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam [1:0] ST_RUN   = 2'd0;   // Normal execution
  localparam [1:0] ST_HOLD  = 2'd1;   // Source still asserted
  localparam [1:0] ST_DELAY = 2'd2;   // Wait before execution
  // Integer forms, cut to register width below
  localparam integer DLY_INT = `RSC_EXEC_DELAY_CYC;
  localparam integer WDT_INT = `RSC_WDT_DIV - 1;
  localparam [9:0] DLY_CYC  = DLY_INT[9:0];   // Execution delay count
  localparam [3:0] WDT_LAST = WDT_INT[3:0];   // Last divider step
  localparam [15:0] CODE_LIMIT = FLASH_64K ? `RSC_LIMIT_64K
                                           : `RSC_LIMIT_32K;

  // ****************************************************************
  // Reset release synchroniser
  // ****************************************************************
  reg        rst_s1_r;                // First stage
  reg        rst_n_r;                 // Released reset copy

  // Release nrst through two flops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire [5:0] async_in;                // Raw asynchronous requests
  reg  [5:0] sync1_r;                 // First stage, read by stage 2
  reg  [5:0] sync2_r;                 // Safe copies

  assign async_in = {vbus_level, usb_bus_reset, cmp0_out,
                     vdd_below_thresh, mcd_oneshot_expired,
                     ~pin_rst_n};

  // Two flops on every asynchronous input
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  wire pin_low   = sync2_r[0];        // External pin held low
  wire mcd_exp   = sync2_r[1];        // One-shot timed out
  wire vdd_low   = sync2_r[2];        // Supply below threshold
  wire cmp_high  = sync2_r[3];        // Comparator output
  wire usb_rst   = sync2_r[4];        // Bus reset signalling
  wire vbus_s    = sync2_r[5];        // Bus-power detect level

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [7:0] en_r;                    // Stored source enables
  reg  [7:0] flags_r;                 // Cause of last reset
  reg  [1:0] state_r;                 // Sequencer state
  reg  [9:0] dly_r;                   // Execution delay count
  reg  [3:0] div_r;                   // Watchdog clock divider

  wire sfr_sel = (sfr_addr == `RSC_STATUS_ADDR);
  wire wr_hit  = sfr_wr & sfr_sel;

  // ****************************************************************
  // Trigger detection
  // ****************************************************************
  // Address above user limit
  wire over_xwr   = program_store_write_enable & xwr_valid &
                    (xwr_addr > CODE_LIMIT);
  wire over_read  = (code_space_read_valid & (code_space_read_addr > CODE_LIMIT)) |
                    (fetch_valid & (fetch_addr > CODE_LIMIT));
  wire flash_err  = over_xwr | over_read | flash_sec_block |
                    (flash_wr_attempt & ~vdd_mon_enabled);

  // Monitor selected while off or low
  wire t_vdd  = en_r[`RSC_BIT_POR] & (vdd_low | ~vdd_mon_enabled);
  wire t_pin  = pin_low;
  wire t_mcd  = en_r[`RSC_BIT_MCD] & mcd_exp;
  wire t_wdt  = wdt_timeout;
  wire t_cmp  = en_r[`RSC_BIT_CMP] & ~cmp_high;
  wire t_usb  = en_r[`RSC_BIT_USB] &
                ((usb_rst & usb_enabled) |
                 (vbus_s == bus_power_polarity));
  wire t_sw   = wr_hit & sfr_wdata[`RSC_BIT_SW];

  // ****************************************************************
  // Cause encoding, one source per reset
  // ****************************************************************
  reg  [7:0] cause;                   // One-hot new flags
  reg        hit;                     // Any source fired

  // Priority pick of the winning source
  always @* begin
    hit   = 1'b1;
    cause = 8'h00;
    if (t_vdd) begin
      cause[`RSC_BIT_POR] = 1'b1;
    end else if (t_pin) begin
      cause[`RSC_BIT_PIN] = 1'b1;
    end else if (t_mcd) begin
      cause[`RSC_BIT_MCD] = 1'b1;
    end else if (flash_err) begin
      cause[`RSC_BIT_FERR] = 1'b1;
    end else if (t_wdt) begin
      cause[`RSC_BIT_WDT] = 1'b1;
    end else if (t_cmp) begin
      cause[`RSC_BIT_CMP] = 1'b1;
    end else if (t_usb) begin
      cause[`RSC_BIT_USB] = 1'b1;
    end else if (t_sw) begin
      cause[`RSC_BIT_SW] = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  // Still-held sources keep the system in reset
  wire held = pin_low | t_vdd;

  // State, cause capture and enables
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_DELAY;
      dly_r   <= 10'h000;
      flags_r <= `RSC_FLAGS_POR;
      en_r    <= `RSC_EN_POR;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (hit) begin
            flags_r <= cause;
            // Enables drop, monitor selection persists
            en_r    <= en_r & (8'h01 << `RSC_BIT_POR);
            state_r <= ST_HOLD;
          end else if (wr_hit) begin
            en_r <= sfr_wdata & `RSC_EN_MASK &
                    ~(8'h01 << `RSC_BIT_SW);
          end
        end
        ST_HOLD: begin
          // Wait for held sources to let go
          if (!held) begin
            dly_r   <= 10'h000;
            state_r <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (held) begin
            state_r <= ST_HOLD;
          end else if (dly_r == DLY_CYC - 10'd1) begin
            state_r <= ST_RUN;
          end else begin
            dly_r <= dly_r + 10'd1;
          end
        end
        default: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  wire in_rst = (state_r != ST_RUN);  // System held in reset

  // System reset, pin drive and enables
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sys_rst_n         <= 1'b0;
      rst_pin_out       <= 1'b0;
      rst_pin_oe        <= 1'b1;
      wdt_force_default <= 1'b1;
      mcd_enable        <= 1'b0;
      vdd_mon_select    <= 1'b1;
    end else begin
      sys_rst_n         <= ~in_rst;
      rst_pin_out       <= 1'b0;
      // Pin driven only for supply resets
      rst_pin_oe        <= in_rst & flags_r[`RSC_BIT_POR];
      wdt_force_default <= in_rst;
      mcd_enable        <= en_r[`RSC_BIT_MCD];
      vdd_mon_select    <= en_r[`RSC_BIT_POR];
    end
  end

  // Watchdog clock enable every twelve cycles
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r      <= 4'h0;
      wdt_clk_en <= 1'b0;
    end else begin
      wdt_clk_en <= (div_r == WDT_LAST);
      if (div_r == WDT_LAST) begin
        div_r <= 4'h0;
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  // Read-modify-write returns enables, flags on bits 0, 3 and 6
  wire [7:0] rmw_view = (en_r & `RSC_EN_MASK) |
                        (flags_r & ~`RSC_EN_MASK);

  // Read data, zero when unselected
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_sel) begin
      if (sfr_rmw) begin
        sfr_rdata <= rmw_view;
      end else begin
        sfr_rdata <= flags_r;
      end
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

endmodule

// File: shared/rsc_map.vh
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ****************************************************************
// Register address and field positions
// ****************************************************************
`define RSC_STATUS_ADDR     8'hef
`define RSC_BIT_PIN         0
`define RSC_BIT_POR         1
`define RSC_BIT_MCD         2
`define RSC_BIT_WDT         3
`define RSC_BIT_SW          4
`define RSC_BIT_CMP         5
`define RSC_BIT_FERR        6
`define RSC_BIT_USB         7

// ****************************************************************
// Reset values
// ****************************************************************
// Cause flags after power-on: only the power-on flag
`define RSC_FLAGS_POR       8'h02
// Enables after power-on: supply monitor selected
`define RSC_EN_POR          8'h02
// Bits that are enables on write, flags on read
`define RSC_EN_MASK         8'hb6

// ****************************************************************
// Flash user code limits
// ****************************************************************
`define RSC_LIMIT_32K       16'h7fff
`define RSC_LIMIT_64K       16'hfbff

// ****************************************************************
// Timing
// ****************************************************************
`define RSC_CLK_MHZ         125
`define RSC_EXEC_DELAY_NS   5000
`define RSC_EXEC_DELAY_CYC  ((`RSC_EXEC_DELAY_NS*`RSC_CLK_MHZ+999)/1000)
`define RSC_MCD_TIMEOUT_US  100
`define RSC_WDT_DIV         12

`endif

// File: verification/rsc_chk_properties.sv
`timescale 1ns/1ps
// ****
// Port checks of the reset controller
// ****
module rsc_chk (
  input wire       clk,
  input wire       nrst,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire       sfr_rmw,
  input wire [7:0] sfr_rdata,
  input wire       pin_rst_n,
  input wire       wdt_timeout,
  input wire       sys_rst_n,
  input wire       rst_pin_out,
  input wire       rst_pin_oe,
  input wire       wdt_force_default,
  input wire       wdt_clk_en,
  input wire       mcd_enable,
  input wire       vdd_mon_select
);
  localparam int DLY = 625;
  logic [10:0] lo_r;   // Cycles spent in reset
  logic [3:0]  gap_r;  // Cycles since divider pulse
  logic        seen_r; // A pulse seen in this run
  wire         sel = sfr_addr == 8'hef;
  // Count reset length and divider spacing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_r   <= 11'h000;
      gap_r  <= 4'h0;
      seen_r <= 1'b0;
    end else begin
      lo_r   <= sys_rst_n ? 11'h000 : lo_r + {10'h000, lo_r != 11'h7ff};
      gap_r  <= wdt_clk_en ? 4'h0 : gap_r + {3'h0, gap_r != 4'hf};
      seen_r <= sys_rst_n && (seen_r || wdt_clk_en);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SW_FORCE:
    assert property (sys_rst_n && sfr_wr && sel && sfr_wdata[4] |-> ##2
      !sys_rst_n) else $error("soft reset not raised");
  AST_WDT_RST:
    assert property (sys_rst_n && wdt_timeout |-> ##2
      !sys_rst_n && !rst_pin_oe) else $error("watchdog reset wrong");
  AST_PIN_QUIET:
    assert property (sys_rst_n |-> !rst_pin_oe && !rst_pin_out)
      else $error("reset pin driven while running");
  AST_EXEC:
    assert property ($rose(sys_rst_n) |-> lo_r >= DLY)
      else $error("reset released too early");
  AST_WDT_DEF:
    assert property (!sys_rst_n |-> wdt_force_default)
      else $error("watchdog default missing");
  AST_WDT_DIV:
    assert property (wdt_clk_en && seen_r |-> gap_r == 4'hb)
      else $error("watchdog tick spacing wrong");
  // Enable lands in the register, then in the output flop
  AST_MCD_WR:
    assert property (sys_rst_n && sfr_wr && sel && !sfr_wdata[4] |-> ##2
      mcd_enable == $past(sfr_wdata[2], 2))
      else $error("detector enable wrong");
  AST_IDLE_RD:
    assert property (!(sfr_rd && sel) |=> sfr_rdata == 8'h00)
      else $error("read data not idle");
  AST_RMW:
    assert property (sys_rst_n && sfr_rd && sfr_rmw && sel |=>
      !sfr_rdata[4] && sfr_rdata[2] == $past(mcd_enable) &&
      sfr_rdata[1] == $past(vdd_mon_select))
      else $error("modify read not enables");
  AST_PIN_RST:
    assert property ($fell(pin_rst_n) && sys_rst_n |-> ##[1:8] !sys_rst_n)
      else $error("pin reset missing");
  cover property (sys_rst_n && sfr_wr && sel && sfr_wdata[4]);
  cover property ($fell(pin_rst_n) && sys_rst_n);
  cover property (sfr_rd && sfr_rmw && sel);
endmodule

// File: verification/rsc_req_model.sv
`timescale 1ns/1ps
// ****
// Reset requesters beside the block
// ****
module rsc_req_model #(
  parameter int PIN_CYC = 1875
) (
  input  wire  clk,
  input  wire  sys_rst_n,
  output logic pin_rst_n,
  output logic mcd_oneshot_expired,
  output logic cmp0_out,
  output logic usb_bus_reset,
  output logic vbus_level,
  output logic wdt_timeout
);
  task automatic idle;
    {pin_rst_n, cmp0_out} = 2'b11;
    {mcd_oneshot_expired, usb_bus_reset, vbus_level, wdt_timeout} = 4'h0;
  endtask
  initial idle();
  // Raise one source until the block enters reset or PIN_CYC cycles pass; the pin is held for PIN_CYC cycles
  task automatic fire(input int k);
    int n;
    n = 0;
    @(negedge clk);
    case (k)
      0: pin_rst_n = 1'b0;
      1: mcd_oneshot_expired = 1'b1;
      2: wdt_timeout = 1'b1;
      3: cmp0_out = 1'b0;
      4: usb_bus_reset = 1'b1;
      default: vbus_level = 1'b1;
    endcase
    while (n < PIN_CYC && (sys_rst_n || k == 0)) begin
      @(negedge clk);
      n++;
    end
    idle();
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
// ****
// Register level bench
// ****
module tb;
  logic        clk = 1'b0, nrst = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  logic        vdd_below_thresh = 1'b0, vdd_mon_enabled = 1'b1;
  logic        usb_enabled = 1'b1, bus_power_polarity = 1'b1;
  logic        program_store_write_enable = 1'b0, flash_wr_attempt = 1'b0;
  logic        xwr_valid = 1'b0, code_space_read_valid = 1'b0, fetch_valid = 1'b0;
  logic        flash_sec_block = 1'b0;
  logic [15:0] xwr_addr = 16'h0000, code_space_read_addr = 16'h0000;
  logic [15:0] fetch_addr = 16'h0000;
  wire  [7:0]  sfr_rdata;
  wire         pin_rst_n, mcd_oneshot_expired, cmp0_out, usb_bus_reset;
  wire         vbus_level, wdt_timeout, sys_rst_n, rst_pin_out, rst_pin_oe;
  wire         wdt_force_default, wdt_clk_en, mcd_enable, vdd_mon_select;
  int          n_errors = 0, total_checks = 0;
  // Enables written, source fired, flag expected
  logic [7:0]  en [7] = '{8'h04, 8'h02, 8'h22, 8'h82, 8'h82, 8'h02, 8'h12};
  int          src [7] = '{1, 2, 3, 4, 5, 0, 6};
  logic [7:0]  fl [7] = '{8'h04, 8'h08, 8'h20, 8'h80, 8'h80, 8'h01, 8'h10};
  rsc_reset_source_controller #(.FLASH_64K(1)) u_dut (.*);
  rsc_req_model u_req (.*);
  always #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(negedge clk);
    {sfr_addr, sfr_rmw, sfr_rd} = {a, m, 1'b1};
    @(negedge clk);
    {sfr_rmw, sfr_rd} = 2'b00;
    chk(sfr_rdata, e);
  endtask
  // Wait for a reset to start and end
  task automatic boot;
    int n;
    n = 0;
    while (sys_rst_n !== 1'b0 && n < 40) begin @(negedge clk); n++; end
    chk({7'h00, sys_rst_n}, 8'h00);
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    chk({7'h00, sys_rst_n}, 8'h01);
  endtask
  task automatic quiet;
    repeat (12) @(negedge clk);
    chk({7'h00, sys_rst_n}, 8'h01);
  endtask
  task automatic flash(input int k, input logic [15:0] a);
    @(negedge clk);
    {xwr_addr, code_space_read_addr, fetch_addr} = {3{a}};
    case (k)
      0: xwr_valid = 1'b1;
      1: code_space_read_valid = 1'b1;
      2: fetch_valid = 1'b1;
      3: flash_sec_block = 1'b1;
      default: {vdd_mon_enabled, flash_wr_attempt} = 2'b01;
    endcase
    @(negedge clk);
    {xwr_valid, code_space_read_valid, fetch_valid, flash_sec_block} = 4'h0;
    {vdd_mon_enabled, flash_wr_attempt} = 2'b10;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    boot();
    rd(8'hef, 1'b0, 8'h02);
    rd(8'hef, 1'b1, 8'h02);
    rd(8'h00, 1'b0, 8'h00);
    wr(8'hef, 8'h06);
    rd(8'hef, 1'b1, 8'h06);
    rd(8'hef, 1'b0, 8'h02);
    quiet();
    wr(8'hef, 8'h02);
    u_req.fire(1);
    quiet();
    for (int i = 0; i < 7; i++) begin
      wr(8'hef, en[i]);
      if (src[i] < 6) u_req.fire(src[i]);
      boot();
      rd(8'hef, 1'b0, fl[i]);
    end
    flash(0, 16'hfc00);
    quiet();
    program_store_write_enable = 1'b1;
    flash(0, 16'hfbff);
    quiet();
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wr(8'hef, 8'h00);
      flash(k, 16'hfc00);
      boot();
      rd(8'hef, 1'b0, 8'h40);
    end
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
bind rsc_reset_source_controller rsc_chk u_chk (.*);
